// File: hw/bbd_cfg.svh
`ifndef BBD_CFG_SVH
`define BBD_CFG_SVH

// device address set by jumper wiring
`define BBD_DEV_ADDR 5'h00

// control byte fields
`define BBD_ADDR_LSB 0
`define BBD_ADDR_MSB 4
`define BBD_ORD_LSB 5
`define BBD_ORD_MSB 7

// order codes
`define BBD_ORD_DATA 3'h0
`define BBD_ORD_STAT 3'h1
`define BBD_ORD_BIN 3'h2
`define BBD_ORD_BIN_IRQ 3'h3
`define BBD_ORD_STOP 3'h4
`define BBD_ORD_PROT 3'h5
`define BBD_ORD_BOUT 3'h6
`define BBD_ORD_BOUT_IRQ 3'h7

// status byte bit positions
`define BBD_ST_READY 0
`define BBD_ST_IN_FLAG 1
`define BBD_ST_OUT_FLAG 2
`define BBD_ST_ERROR 3
`define BBD_ST_DEV_LSB 4
`define BBD_ST_DEV_MSB 7

// reset values
`define BBD_BYTE_RST 8'h00
`define BBD_ORD_RST 3'h0
`define BBD_LINE_IDLE 8'hFF

// bus timing: strobe width and longest gap before the data strobe
`define BBD_CLK_NS 10
`define BBD_STROBE_NS 880
`define BBD_GAP_MAX_NS 4400
`define BBD_GAP_MAX_CYC (`BBD_GAP_MAX_NS / `BBD_CLK_NS)

`endif

// File: hw/bbd_pkg.sv
package bbd_pkg;

  // bus pins as seen at the controller, all active low
  typedef struct packed {
    logic [7:0] out_line_n;
    logic control_byte_strobe_n;
    logic data_out_strobe_n;
    logic data_in_strobe_n;
  } bbd_pins_s;

  // conditions reported by the device behind the controller
  typedef struct packed {
    logic ready;
    logic in_avail;
    logic out_room;
    logic error;
    logic [3:0] dev_bits;
  } bbd_dev_s;

  // whole controller state
  typedef struct packed {
    logic co_m;
    logic co_s;
    logic do_m;
    logic do_s;
    logic do_p;
    logic di_m;
    logic di_s;
    logic di_p;
    logic [7:0] od_m;
    logic [7:0] od_s;
    logic addr_sel;
    logic sel_p;
    logic conn;
    logic [2:0] order;
    logic [7:0] data_reg;
    logic data_load;
    logic [7:0] func_byte;
    logic func_load;
    logic blk_in;
    logic blk_out;
    logic armed;
    logic protect;
    logic ext_irq;
    logic err;
    logic in_oe;
    logic [7:0] in_drv_n;
  } bbd_state_s;

endpackage

// File: hw/bbd_ctrl.sv
// What this block does
// - order 0 moves a data byte, direction from the instruction type
// - order 1 returns status on input, takes a function byte on output
// - order 2 starts block input, with either instruction type
// - order 3 starts block input and arms an end interrupt
// - order 4 stops block transfer, interrupts if it was armed
// - order 5 allows protected writes until the transfer ends
// - order 6 starts block output, with either instruction type
// - order 7 starts block output and arms an end interrupt
// - status bit 0 shows device ready
// - status bit 1 shows a byte waiting for the processor
// - status bit 2 shows room for a byte from the processor
// - status bit 3 latches errors, cleared by a status read
// - status bits 4 to 7 are device specific
// - low five lines match our address, qualified by control strobe
// - connect flag set by control strobe on match, ended by data strobe
// - data strobes are obeyed only while connected
// - data register loads on connected and data-out strobe
// - connection waits 880 ns to 4.4 us for the data strobe
// - function output uses the data output sequence, keyed by order
// - function data byte may carry extra function detail
// - order bits latched during control strobe, kept for later use
// - order latched by the address-selected signal
// - connection drops when either data strobe returns high
// - on input, order 0 gives data and order 1 gives status
`timescale 1ns/100ps
`include "bbd_cfg.svh"

module bbd_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // byte bus pins
  input wire bbd_pkg::bbd_pins_s pins,
  // input data lines, open collector, active low
  output logic [7:0] in_line_n,
  output logic in_line_oe,
  // device side
  input wire bbd_pkg::bbd_dev_s dev,
  input wire logic [7:0] dev_in_data,
  input wire logic blk_done,
  output logic [7:0] data_reg,
  output logic data_load,
  output logic [7:0] func_byte,
  output logic func_load,
  output logic [2:0] order,
  output logic connected,
  output logic blk_in_run,
  output logic blk_out_run,
  output logic blk_irq_armed,
  output logic protect_override,
  output logic ext_irq,
  output logic status_err
);

  bbd_pkg::bbd_state_s q;
  bbd_pkg::bbd_state_s n;
  logic do_end;
  logic di_end;
  logic [7:0] status_now;

  function automatic logic addr_match(input logic [7:0] od_n);
    addr_match = (~od_n[`BBD_ADDR_MSB:`BBD_ADDR_LSB]) == `BBD_DEV_ADDR;
  endfunction

  function automatic logic [2:0] ord_of(input logic [7:0] od_n);
    ord_of = ~od_n[`BBD_ORD_MSB:`BBD_ORD_LSB];
  endfunction

  function automatic logic [7:0] stat_byte(
    input bbd_pkg::bbd_dev_s d,
    input logic e
  );
    logic [7:0] s;
    s = `BBD_BYTE_RST;
    s[`BBD_ST_READY] = d.ready;
    s[`BBD_ST_IN_FLAG] = d.in_avail;
    s[`BBD_ST_OUT_FLAG] = d.out_room;
    s[`BBD_ST_ERROR] = e;
    s[`BBD_ST_DEV_MSB:`BBD_ST_DEV_LSB] = d.dev_bits;
    stat_byte = s;
  endfunction

  assign do_end = q.do_p & ~q.do_s;
  assign di_end = q.di_p & ~q.di_s;
  assign status_now = stat_byte(dev, q.err);

  always_comb
  begin
    n = q;
    // two-stage synchronisers, strobes turned active high
    n.co_m = ~pins.control_byte_strobe_n;
    n.co_s = q.co_m;
    n.do_m = ~pins.data_out_strobe_n;
    n.do_s = q.do_m;
    n.do_p = q.do_s;
    n.di_m = ~pins.data_in_strobe_n;
    n.di_s = q.di_m;
    n.di_p = q.di_s;
    n.od_m = pins.out_line_n;
    n.od_s = q.od_m;
    n.data_load = 1'b0;
    n.func_load = 1'b0;
    n.ext_irq = 1'b0;
    // address decode qualified by the control strobe
    n.addr_sel = q.co_s & addr_match(q.od_s);
    n.sel_p = q.addr_sel;
    // order latched while selected, held until next selection
    if (q.addr_sel)
    begin
      n.order = ord_of(q.od_s);
    end
    // device finished the block; a new order below still wins
    if (blk_done & (q.blk_in | q.blk_out))
    begin
      n.blk_in = 1'b0;
      n.blk_out = 1'b0;
      n.ext_irq = q.armed;
      n.armed = 1'b0;
      n.protect = 1'b0;
    end
    // connect on a fresh selection, then act on block orders
    if (q.addr_sel & ~q.sel_p)
    begin
      n.conn = 1'b1;
      case (ord_of(q.od_s))
        `BBD_ORD_BIN:
        begin
          n.blk_in = 1'b1;
          n.blk_out = 1'b0;
          n.armed = 1'b0;
        end
        `BBD_ORD_BIN_IRQ:
        begin
          n.blk_in = 1'b1;
          n.blk_out = 1'b0;
          n.armed = 1'b1;
        end
        `BBD_ORD_STOP:
        begin
          n.blk_in = 1'b0;
          n.blk_out = 1'b0;
          n.ext_irq = q.armed & (q.blk_in | q.blk_out);
          n.armed = 1'b0;
          n.protect = 1'b0;
        end
        `BBD_ORD_PROT:
        begin
          n.protect = 1'b1;
        end
        `BBD_ORD_BOUT:
        begin
          n.blk_out = 1'b1;
          n.blk_in = 1'b0;
          n.armed = 1'b0;
        end
        `BBD_ORD_BOUT_IRQ:
        begin
          n.blk_out = 1'b1;
          n.blk_in = 1'b0;
          n.armed = 1'b1;
        end
        default:
        begin
          n.conn = 1'b1;
        end
      endcase
    end
    // data-out phase only while connected
    if (q.conn & q.do_s)
    begin
      if (q.order == `BBD_ORD_DATA)
      begin
        n.data_reg = ~q.od_s;
        n.data_load = ~q.do_p;
      end
      else if (q.order == `BBD_ORD_STAT)
      begin
        n.func_byte = ~q.od_s;
        n.func_load = ~q.do_p;
      end
    end
    // data-in phase: drive data or status while connected
    n.in_oe = q.conn & q.di_s & ((q.order == `BBD_ORD_DATA) |
      (q.order == `BBD_ORD_STAT));
    n.in_drv_n = (q.order == `BBD_ORD_STAT) ? ~status_now :
      ~dev_in_data;
    // error flag: status read clears, a new error wins
    if (q.conn & di_end & (q.order == `BBD_ORD_STAT))
    begin
      n.err = 1'b0;
    end
    if (dev.error)
    begin
      n.err = 1'b1;
    end
    // connection ends when a data strobe returns high
    if (q.conn & (do_end | di_end))
    begin
      n.conn = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
      q.od_m <= `BBD_LINE_IDLE;
      q.od_s <= `BBD_LINE_IDLE;
      q.in_drv_n <= `BBD_LINE_IDLE;
    end
    else
    begin
      q <= n;
    end
  end

  assign in_line_n = q.in_drv_n;
  assign in_line_oe = q.in_oe;
  assign data_reg = q.data_reg;
  assign data_load = q.data_load;
  assign func_byte = q.func_byte;
  assign func_load = q.func_load;
  assign order = q.order;
  assign connected = q.conn;
  assign blk_in_run = q.blk_in;
  assign blk_out_run = q.blk_out;
  assign blk_irq_armed = q.armed;
  assign protect_override = q.protect;
  assign ext_irq = q.ext_irq;
  assign status_err = q.err;

  // checks

  sequence sel_edge_s;
    q.addr_sel && !q.sel_p;
  endsequence

  sequence do_close_s;
    q.conn && do_end;
  endsequence

  addr_qualify_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    q.addr_sel |-> $past(q.co_s) && $past(addr_match(q.od_s)))
    else $error("address select without strobe and match");

  conn_set_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    sel_edge_s |=> q.conn && q.order == $past(ord_of(q.od_s)))
    else $error("selection did not connect or latch order");

  conn_drop_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    do_close_s and !(q.addr_sel && !q.sel_p) |=> !q.conn)
    else $error("connection held after data-out strobe ended");

  conn_hold_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    q.conn && !q.do_p && !q.di_p |=> q.conn)
    else $error("connection lost while waiting for data strobe");

  load_gate_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    q.data_load |-> $past(q.conn) && $past(q.do_s) &&
      q.data_reg == ~$past(q.od_s))
    else $error("data register loaded outside connection");

  drive_gate_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    q.in_oe |-> $past(q.conn) && $past(q.di_s))
    else $error("input lines driven while not connected");

  status_drive_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    q.in_oe && $past(q.order) == `BBD_ORD_STAT |->
      q.in_drv_n == ~$past(status_now))
    else $error("status byte not driven for status order");

  err_sticky_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    dev.error |=> q.err [*1] ##0 status_err)
    else $error("error event lost");

  stop_irq_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    sel_edge_s ##0 ord_of(q.od_s) == `BBD_ORD_STOP ##0
      (q.armed && (q.blk_in || q.blk_out)) |=> ext_irq && !blk_in_run &&
      !blk_out_run)
    else $error("stop did not halt or interrupt");

  blk_in_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    sel_edge_s ##0 ord_of(q.od_s) == `BBD_ORD_BIN |=>
      blk_in_run && !blk_irq_armed)
    else $error("block input not started");

  blk_out_irq_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    sel_edge_s ##0 ord_of(q.od_s) == `BBD_ORD_BOUT_IRQ |=>
      blk_out_run && blk_irq_armed)
    else $error("armed block output not started");

  protect_end_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    blk_done && (q.blk_in || q.blk_out) && !(q.addr_sel && !q.sel_p &&
      ord_of(q.od_s) == `BBD_ORD_PROT) |=> !protect_override)
    else $error("protect state kept after transfer end");

endmodule // bbd_ctrl

// File: tb/bbd_cpu.sv
`timescale 1ns/100ps
module bbd_cpu (
  // clock
  input wire logic mclk,
  // bus pins driven by the processor
  output bbd_pkg::bbd_pins_s pins
);
  initial pins = {8'hFF, 3'b111};
  // one two-phase transfer: control byte, gap, data or input strobe
  task automatic xfer(input logic [7:0] cb, input logic rd,
                      input logic [7:0] db, input int gap);
    @(negedge mclk);
    pins.out_line_n <= ~cb;
    repeat (22) @(negedge mclk);
    pins.control_byte_strobe_n <= 1'b0;
    repeat (88) @(negedge mclk);
    pins.control_byte_strobe_n <= 1'b1;
    @(negedge mclk);
    // lines no longer hold the control byte
    pins.out_line_n <= rd ? cb : ~db;
    repeat (gap) @(negedge mclk);
    if (rd)
      pins.data_in_strobe_n <= 1'b0;
    else
      pins.data_out_strobe_n <= 1'b0;
    repeat (88) @(negedge mclk);
    pins.data_in_strobe_n <= 1'b1;
    pins.data_out_strobe_n <= 1'b1;
    @(negedge mclk);
    pins.out_line_n <= ~pins.out_line_n;
    repeat (10) @(negedge mclk);
  endtask
endmodule // bbd_cpu

// File: tb/testbench.sv
`timescale 1ns/100ps
`include "bbd_cfg.svh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module testbench;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  wire bbd_pkg::bbd_pins_s pins;
  bbd_pkg::bbd_dev_s dev = '0;
  logic [7:0] din = 8'h00;
  logic blk_done = 1'b0;
  logic [7:0] in_n, dreg, fbyte, b, e8, d;
  logic [2:0] ord;
  logic oe, dload, fload, conn, bin, bout, arm, prot, irq, serr;
  logic oe_q = 1'b0;
  logic [7:0] exp_q[$];
  logic [31:0] rs = 32'hFD02;
  logic [7:0] tbl [8] = '{8'h6A, 8'hBB, 8'h00, 8'hF6,
                          8'h80, 8'h58, 8'hC4, 8'h90};
  int ic [8] = '{0, 0, 1, 1, 2, 2, 2, 2};
  int failures = 0;
  int tests_run = 0;
  int irq_n = 0;
  always #5 mclk = ~mclk;
  bbd_cpu cpu (.mclk(mclk), .pins(pins));
  bbd_ctrl dut (.mclk(mclk), .rstn(rstn), .pins(pins),
    .in_line_n(in_n), .in_line_oe(oe), .dev(dev), .dev_in_data(din),
    .blk_done(blk_done), .data_reg(dreg), .data_load(dload),
    .func_byte(fbyte), .func_load(fload), .order(ord),
    .connected(conn), .blk_in_run(bin), .blk_out_run(bout),
    .blk_irq_armed(arm), .protect_override(prot), .ext_irq(irq),
    .status_err(serr));
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  function automatic logic [7:0] stat(input logic er);
    return {dev.dev_bits, er, dev.out_room, dev.in_avail, dev.ready};
  endfunction
  task automatic wrap_up();
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watcher: every delivered byte takes the oldest note
  always @(negedge mclk)
  begin
    oe_q <= oe;
    if (irq !== 1'b0)
      irq_n++;
    if (dload !== 1'b0 || fload !== 1'b0 || (oe !== 1'b0 && oe_q !== 1'b1))
    begin
      b = dload ? dreg : fload ? fbyte : ~in_n;
      `CHK("queued", 1'b1, exp_q.size() != 0)
      if (exp_q.size() != 0)
      begin
        e8 = exp_q.pop_front();
        `CHK("byte", e8, b)
      end
    end
  end
  initial
  begin
    #200000;
    failures++;
    wrap_up();
  end
  initial
  begin
    repeat (20) @(negedge mclk);
    rstn = 1'b1;
    repeat (2) @(negedge mclk);
    // data out at shortest and longest gap
    for (int g = 88; g <= 440; g += 352)
    begin
      d = rnd();
      exp_q.push_back(d);
      cpu.xfer({`BBD_ORD_DATA, `BBD_DEV_ADDR}, 1'b0, d, g);
      `CHK("conn", 1'b0, conn)
    end
    // another address: nothing may load
    cpu.xfer({`BBD_ORD_DATA, `BBD_DEV_ADDR ^ 5'h01}, 1'b0, rnd(), 88);
    // function byte
    d = rnd();
    exp_q.push_back(d);
    cpu.xfer({`BBD_ORD_STAT, `BBD_DEV_ADDR}, 1'b0, d, 100);
    `CHK("order", `BBD_ORD_STAT, ord)
    // data in
    din = rnd();
    exp_q.push_back(din);
    cpu.xfer({`BBD_ORD_DATA, `BBD_DEV_ADDR}, 1'b1, 8'h00, 90);
    // error then two status reads
    dev = rnd();
    dev.error = 1'b1;
    @(negedge mclk);
    dev.error = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      exp_q.push_back(stat(k == 0));
      cpu.xfer({`BBD_ORD_STAT, `BBD_DEV_ADDR}, 1'b1, 8'h00, 88);
      `CHK("err", 1'b0, serr)
    end
    // block orders, stop and end of block
    for (int i = 0; i < 8; i++)
    begin
      if (i == 2)
      begin
        blk_done = 1'b1;
        @(negedge mclk);
        blk_done = 1'b0;
        repeat (3) @(negedge mclk);
      end
      else
        cpu.xfer({tbl[i][7:5], `BBD_DEV_ADDR}, tbl[i][4], rnd(), 88);
      `CHK("blk", tbl[i][3:0], {bin, bout, arm, prot})
      `CHK("irq", ic[i], irq_n)
    end
    `CHK("left", 0, exp_q.size())
    wrap_up();
  end
endmodule // testbench
